/* File: hw/psseq_defines.svh */
// Register map, field positions, reset values and timing counts of the
// parameter set sequencer. Definitions only; included by bare name.
`ifndef PSSEQ_DEFINES_SVH
`define PSSEQ_DEFINES_SVH

// Byte offsets of the word registers on the AXI4-Lite slave
`define PSSEQ_OFF_CTRL 8'h00
`define PSSEQ_OFF_COUNT 8'h04
`define PSSEQ_OFF_CMD 8'h08
`define PSSEQ_OFF_SEL 8'h0c
`define PSSEQ_OFF_DATA 8'h10
`define PSSEQ_OFF_STATUS 8'h14
`define PSSEQ_OFF_ACTIVE 8'h18

// Control register fields
`define PSSEQ_CTRL_EN 0
`define PSSEQ_CTRL_STEP_LSB 1
`define PSSEQ_CTRL_STEP_MSB 2
`define PSSEQ_CTRL_RST_LSB 4
`define PSSEQ_CTRL_RST_MSB 5
`define PSSEQ_CTRL_INV1 8
`define PSSEQ_CTRL_INV2 9
`define PSSEQ_CTRL_MASK 32'h0000_0337
`define PSSEQ_CTRL_RST 32'h0000_0000

// Command register and status register fields
`define PSSEQ_CMD_STEP 0
`define PSSEQ_STAT_RUN 8
`define PSSEQ_STAT_WAIT 9
`define PSSEQ_STAT_LOAD 10

// Set count: at most 64 sets per cycle
`define PSSEQ_MAX_SETS 64
`define PSSEQ_COUNT_RST 7'h40

// AXI responses
`define PSSEQ_RESP_OKAY 2'b00
`define PSSEQ_RESP_SLVERR 2'b10

// Input line settle window
`define PSSEQ_CLK_PERIOD_NS 20
`define PSSEQ_SETTLE_NS 1000
`define PSSEQ_SETTLE_CYC ((`PSSEQ_SETTLE_NS + `PSSEQ_CLK_PERIOD_NS - 1) / `PSSEQ_CLK_PERIOD_NS)

`endif

/* File: hw/psseq_pkg.sv */
// Types shared by the parameter set sequencer files.
// Assumes psseq_defines.svh supplies the numeric constants.
package psseq_pkg;

  typedef logic [5:0] psseq_idx_t;

  typedef enum logic [1:0]
  {
    STEP_CONT = 2'b00,
    STEP_LINE1 = 2'b01,
    STEP_LINE2 = 2'b10,
    STEP_SW = 2'b11
  } psseq_step_e;

  typedef enum logic [1:0]
  {
    RST_NONE = 2'b00,
    RST_LINE1 = 2'b01,
    RST_LINE2 = 2'b10,
    RST_RSVD = 2'b11
  } psseq_rst_e;

  typedef enum logic [1:0]
  {
    ST_OFF = 2'b00,
    ST_FETCH = 2'b01,
    ST_RUN = 2'b10
  } psseq_state_e;

endpackage

/* File: hw/psseq_mem.sv */
// Parameter set store: one word per set, one write port, registered read.
// Assumes a single clock; contents are not reset.
`timescale 1ns/1ns
module psseq_mem #(
  parameter int DEPTH = 64,
  parameter int WIDTH = 32
)
(
  input wire logic aclk,
  input wire logic we,
  input wire psseq_pkg::psseq_idx_t waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire psseq_pkg::psseq_idx_t raddr,
  output logic [WIDTH-1:0] rdata
);
  import psseq_pkg::*;

  logic [WIDTH-1:0] mem [DEPTH];

  generate
    if (DEPTH < 2 || DEPTH > 64)
    begin : g_bad_depth
      $error("psseq_mem: DEPTH must be 2..64");
    end
  endgenerate

  always_ff @(posedge aclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge aclk)
  begin
    rdata <= mem[raddr];
  end

endmodule

/* File: hw/psseq_core.sv */
// Parameter set sequencer, controlled advance mode, with AXI4-Lite registers.
// Assumes frame_trigger and input_line are synchronous to aclk; trigger is a one-cycle pulse.
//
// The address map and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ns
`include "psseq_defines.svh"

// Functional notes
// - Sets advance in ascending index order.
// - Continuous source advances on every frame trigger.
// - Line source advancing depends on sampled line.
// - Disabled source advances only on software step.
// - Set count defines cycle length, at most 64.
// - Enabling loads set 0 into active set.
// - Continuous: first trigger after enable uses set 1.
// - After highest index, next advance wraps to zero.
// - Disabling restores pre-enable active values.
// - Line 1 or 2 selectable as restart source.
// - High restart line at trigger selects set 0.
// - Restart beats continuous advance on same trigger.
// - Line change leaves waiting status, drops triggers.
// - Line high loads next set; low keeps current.
module psseq_core #(
  parameter int AW = 8,
  parameter int PW = 32,
  parameter int MAX_SETS = `PSSEQ_MAX_SETS,
  parameter int SETTLE_CYC = `PSSEQ_SETTLE_CYC
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic frame_trigger,
  input wire logic [1:0] input_line,
  output logic [PW-1:0] active_params,
  output psseq_pkg::psseq_idx_t set_index,
  output logic waiting_for_trigger,
  output logic sequencer_running
);
  import psseq_pkg::*;

  generate
    if (PW < 1 || PW > 32 || MAX_SETS < 2 || MAX_SETS > `PSSEQ_MAX_SETS || AW < 8)
    begin : g_bad_param
      $error("psseq_core: PW 1..32, MAX_SETS 2..64, AW >= 8");
    end
    if (SETTLE_CYC < 1 || SETTLE_CYC > 65535)
    begin : g_bad_settle
      $error("psseq_core: SETTLE_CYC must be 1..65535");
    end
  endgenerate

  localparam logic [6:0] MAX_COUNT = 7'(MAX_SETS);
  localparam logic [15:0] SETTLE_LOAD = 16'(SETTLE_CYC);

  // Only the low byte of the address selects a register; higher bits must be zero
  function automatic logic reg_hit(input logic [AW-1:0] addr);
    logic [7:0] a;
    a = addr[7:0];
    reg_hit = ((addr >> 8) == '0) &&
              (a == `PSSEQ_OFF_CTRL || a == `PSSEQ_OFF_COUNT || a == `PSSEQ_OFF_CMD ||
               a == `PSSEQ_OFF_SEL || a == `PSSEQ_OFF_DATA || a == `PSSEQ_OFF_STATUS ||
               a == `PSSEQ_OFF_ACTIVE);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  logic [31:0] ctrl;
  logic [6:0] set_count;
  psseq_idx_t store_sel;
  logic sw_step;
  logic [PW-1:0] backup;
  logic [PW-1:0] mem_rdata;
  psseq_state_e state;
  logic en_q;
  logic [1:0] line_prev;
  logic [15:0] settle_cnt;
  logic aw_have;
  logic w_have;
  logic [AW-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic [7:0] wr_off;
  logic wr_ok;
  logic [6:0] wr_count;

  logic enable;
  psseq_step_e step_src;
  psseq_rst_e rst_src;
  logic [1:0] eff_line;
  logic line_busy;
  logic trig_ok;
  logic restart_hit;
  logic adv_due;
  logic start;
  logic stop;
  logic load_go;
  psseq_idx_t wrap_index;
  psseq_idx_t next_index;

  assign enable = ctrl[`PSSEQ_CTRL_EN];
  assign step_src = psseq_step_e'(ctrl[`PSSEQ_CTRL_STEP_MSB:`PSSEQ_CTRL_STEP_LSB]);
  assign rst_src = psseq_rst_e'(ctrl[`PSSEQ_CTRL_RST_MSB:`PSSEQ_CTRL_RST_LSB]);
  assign eff_line = input_line ^ {ctrl[`PSSEQ_CTRL_INV2], ctrl[`PSSEQ_CTRL_INV1]};
  assign start = enable && !en_q;
  assign stop = !enable && en_q;

  // Any line edge opens a settle window; triggers inside it are dropped
  assign line_busy = (input_line != line_prev) || (settle_cnt != 16'h0000);
  assign trig_ok = frame_trigger && !line_busy && (state == ST_RUN);
  assign waiting_for_trigger = !line_busy && (state != ST_FETCH);
  assign sequencer_running = (state != ST_OFF);

  // Restart line sampled at the trigger; invert flips its sense
  assign restart_hit = trig_ok && ((rst_src == RST_LINE1 && eff_line[0]) ||
                                   (rst_src == RST_LINE2 && eff_line[1]));

  always_comb
  begin
    case (step_src)
      STEP_CONT: adv_due = trig_ok;
      STEP_LINE1: adv_due = trig_ok && eff_line[0];
      STEP_LINE2: adv_due = trig_ok && eff_line[1];
      STEP_SW: adv_due = sw_step && (state == ST_RUN);
      default: adv_due = 1'b0;
    endcase
  end

  // A count lowered under the current index still wraps cleanly
  assign wrap_index = ({1'b0, set_index} >= set_count - 7'h01) ? 6'h00 : set_index + 6'h01;

  always_comb
  begin
    if (start || restart_hit)
    begin
      next_index = 6'h00;
    end
    else if (adv_due)
    begin
      next_index = wrap_index;
    end
    else
    begin
      next_index = set_index;
    end
  end

  assign load_go = start || restart_hit || adv_due;

  psseq_mem #(
    .DEPTH(MAX_SETS),
    .WIDTH(PW)
  ) u_mem (
    .aclk(aclk),
    .we(wr_fire && wr_off == `PSSEQ_OFF_DATA),
    .waddr(store_sel),
    .wdata(w_data[PW-1:0]),
    .raddr(next_index),
    .rdata(mem_rdata)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      line_prev <= 2'b00;
      settle_cnt <= 16'h0000;
    end
    else
    begin
      line_prev <= input_line;
      if (input_line != line_prev)
      begin
        settle_cnt <= SETTLE_LOAD;
      end
      else if (settle_cnt != 16'h0000)
      begin
        settle_cnt <= settle_cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= ST_OFF;
      en_q <= 1'b0;
    end
    else
    begin
      en_q <= enable;
      if (stop)
      begin
        state <= ST_OFF;
      end
      else if (load_go)
      begin
        state <= ST_FETCH;
      end
      else if (state == ST_FETCH)
      begin
        state <= ST_RUN;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      set_index <= 6'h00;
    end
    else if (load_go)
    begin
      set_index <= next_index;
    end
  end

  // The active set is saved on enable and given back on disable
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      backup <= '0;
    end
    else if (start)
    begin
      backup <= active_params;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      active_params <= '0;
    end
    else if (stop)
    begin
      active_params <= backup;
    end
    else if (state == ST_FETCH)
    begin
      active_params <= mem_rdata;
    end
    else if (wr_fire && wr_off == `PSSEQ_OFF_ACTIVE && state == ST_OFF && !enable)
    begin
      active_params <= PW'(merge(32'(active_params), w_data, w_strb));
    end
  end

  // Write channel: address and data may come in either order
  assign s_axi_awready = !aw_have && !s_axi_bvalid;
  assign s_axi_wready = !w_have && !s_axi_bvalid;
  assign wr_fire = aw_have && w_have;
  assign wr_off = aw_addr[7:0];
  assign wr_ok = reg_hit(aw_addr);
  // Counts of zero or above the maximum are clamped to stay inside the cycle
  assign wr_count = (w_data[6:0] == 7'h00) ? 7'h01 :
                    ((w_data[31:7] != '0 || w_data[6:0] > MAX_COUNT) ? MAX_COUNT : w_data[6:0]);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PSSEQ_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `PSSEQ_RESP_OKAY : `PSSEQ_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl <= `PSSEQ_CTRL_RST;
      set_count <= `PSSEQ_COUNT_RST;
      store_sel <= 6'h00;
      sw_step <= 1'b0;
    end
    else
    begin
      sw_step <= wr_fire && wr_off == `PSSEQ_OFF_CMD && w_strb[0] && w_data[`PSSEQ_CMD_STEP];
      if (wr_fire && wr_off == `PSSEQ_OFF_CTRL)
      begin
        ctrl <= merge(ctrl, w_data, w_strb) & `PSSEQ_CTRL_MASK;
      end
      if (wr_fire && wr_off == `PSSEQ_OFF_COUNT && w_strb[0])
      begin
        set_count <= wr_count;
      end
      if (wr_fire && wr_off == `PSSEQ_OFF_SEL && w_strb[0])
      begin
        store_sel <= w_data[5:0];
      end
    end
  end

  // Read channel: one read at a time, data one cycle after the address
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PSSEQ_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= reg_hit(s_axi_araddr) ? `PSSEQ_RESP_OKAY : `PSSEQ_RESP_SLVERR;
      s_axi_rdata <= 32'h0000_0000;
      // A shift rather than a part-select, so that AW of 8 leaves no empty range
      if ((s_axi_araddr >> 8) == '0)
      begin
        case (s_axi_araddr[7:0])
          `PSSEQ_OFF_CTRL: s_axi_rdata <= ctrl;
          `PSSEQ_OFF_COUNT: s_axi_rdata <= {25'h0000000, set_count};
          `PSSEQ_OFF_SEL: s_axi_rdata <= {26'h0000000, store_sel};
          `PSSEQ_OFF_STATUS: s_axi_rdata <= {21'h000000, state == ST_FETCH, waiting_for_trigger,
                                             sequencer_running, 2'b00, set_index};
          `PSSEQ_OFF_ACTIVE: s_axi_rdata <= 32'(active_params);
          default: s_axi_rdata <= 32'h0000_0000;
        endcase
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

/* File: tb/psseq_core_checker.sv */
// Port checker for the sequencer core.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module psseq_core_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic frame_trigger,
  input wire logic [1:0] input_line,
  input wire logic [31:0] active_params,
  input wire psseq_pkg::psseq_idx_t set_index,
  input wire logic waiting_for_trigger,
  input wire logic sequencer_running
);
  import psseq_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  start_index_a: assert property ($rose(sequencer_running) |-> set_index == 6'h00)
    else $error("index not zero at start");
  start_fetch_a: assert property ($rose(sequencer_running) |-> !waiting_for_trigger)
    else $error("waiting during set fetch");
  line_busy_a: assert property ($changed(input_line) |-> !waiting_for_trigger)
    else $error("waiting while a line changes");
  drop_trig_a: assert property (frame_trigger && !waiting_for_trigger |=> $stable(set_index))
    else $error("trigger taken while busy");
  off_hold_a: assert property (!sequencer_running ##1 !sequencer_running |-> $stable(set_index))
    else $error("index moved while off");
  step_order_a: assert property (sequencer_running && $changed(set_index)
    |-> set_index == 6'h00 || set_index == $past(set_index) + 6'h01)
    else $error("index skipped");
  hold_params_a: assert property ($past(sequencer_running, 2) && sequencer_running
    && $past(set_index) == set_index && $past(set_index, 2) == set_index |-> $stable(active_params))
    else $error("active set changed without a step");
  off_trig_a: assert property (!sequencer_running && frame_trigger |=> $stable(active_params))
    else $error("trigger acted while off");
  cover property (sequencer_running && frame_trigger && waiting_for_trigger);
  cover property ($changed(input_line));
  cover property ($fell(sequencer_running));
endmodule

bind psseq_core psseq_core_checker chk (.aclk(aclk), .aresetn(aresetn), .frame_trigger(frame_trigger),
  .input_line(input_line), .active_params(active_params), .set_index(set_index),
  .waiting_for_trigger(waiting_for_trigger), .sequencer_running(sequencer_running));

/* File: tb/psseq_far.sv */
// Far side: frame trigger source and the two input line drivers.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ns
module psseq_far (
  input wire logic aclk,
  input wire logic waiting_for_trigger,
  output logic frame_trigger,
  output logic [1:0] input_line
);
  initial
  begin
    frame_trigger = 1'b0;
    input_line = 2'b00;
  end
  task automatic set_line(input int n, input logic v);
    input_line[n] <= v;
    @(posedge aclk);
  endtask
  // Waits for the device to wait, so a settling line never eats a trigger
  task automatic trig();
    int n;
    n = 0;
    do
    begin
      @(negedge aclk);
      n++;
    end
    while (!waiting_for_trigger && n < 200);
    @(posedge aclk);
    frame_trigger <= 1'b1;
    @(posedge aclk);
    frame_trigger <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
  // Misbehaves on purpose: line change and trigger in one cycle
  task automatic rude(input int n, input logic v);
    input_line[n] <= v;
    frame_trigger <= 1'b1;
    @(posedge aclk);
    frame_trigger <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
endmodule

/* File: tb/psseq_core_tb.sv */
// Self-checking bench: AXI4-Lite master tasks plus far-side model.
// Assumes psseq_core with a short line settle window.
`timescale 1ns/1ns
module psseq_core_tb;
  import psseq_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, active_params;
  logic [1:0] bresp, rresp, input_line;
  logic frame_trigger, waiting_for_trigger, sequencer_running;
  psseq_idx_t set_index;
  int mismatches, total_checks, cycles;
  psseq_core #(.SETTLE_CYC(4)) uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .frame_trigger(frame_trigger), .input_line(input_line),
    .active_params(active_params), .set_index(set_index), .waiting_for_trigger(waiting_for_trigger),
    .sequencer_running(sequencer_running));
  psseq_far far (.aclk(aclk), .waiting_for_trigger(waiting_for_trigger), .frame_trigger(frame_trigger),
    .input_line(input_line));
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  function automatic logic [31:0] pw(input int k);
    return 32'h0000_a000 | k;
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b;
    logic [1:0] rs;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(negedge aclk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (aw)
        awvalid <= 1'b0;
      if (w)
        wvalid <= 1'b0;
    end
    while (!b);
    bready <= 1'b0;
    check("bresp", {30'h0, rs}, {30'h0, er});
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
    logic ar, r;
    logic [31:0] d;
    logic [1:0] rs;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge aclk);
      ar = arvalid && arready;
      r = rvalid;
      d = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ar)
        arvalid <= 1'b0;
    end
    while (!r);
    rready <= 1'b0;
    check("rdata", d, ex);
    check("rresp", {30'h0, rs}, {30'h0, er});
  endtask
  task automatic chk_set(input int k);
    check("set_index", {26'h0, set_index}, k);
    check("active_params", active_params, pw(k));
  endtask
  // Disable first so every scenario starts from a fresh cycle
  task automatic en(input logic [31:0] c);
    axw(8'h00, 32'h0, 2'b00);
    axw(8'h00, c, 2'b00);
    repeat (2) @(posedge aclk);
    chk_set(0);
  endtask
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      final_report();
    end
  end
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    axr(8'h00, 32'h0, 2'b00);
    axr(8'h04, 32'h40, 2'b00);
    axw(8'h04, 32'd100, 2'b00);
    axr(8'h04, 32'h40, 2'b00);
    axw(8'h04, 32'h0, 2'b00);
    axr(8'h04, 32'h1, 2'b00);
    axw(8'h04, 32'd6, 2'b00);
    axr(8'h04, 32'h6, 2'b00);
    axr(8'hfc, 32'h0, 2'b10);
    axw(8'h1c, 32'h0, 2'b10);
    for (int k = 0; k < 6; k++)
    begin
      axw(8'h0c, k, 2'b00);
      axw(8'h10, pw(k), 2'b00);
    end
    axw(8'h18, 32'h0000_beef, 2'b00);
    $display("test registers done");
    en(32'h1);
    for (int i = 1; i < 8; i++)
    begin
      far.trig();
      chk_set(i % 6);
    end
    axw(8'h00, 32'h0, 2'b00);
    repeat (2) @(posedge aclk);
    check("restored", active_params, 32'h0000_beef);
    far.trig();
    check("off_index", {26'h0, set_index}, 32'h1);
    $display("test continuous done");
    for (int l = 1; l < 3; l++)
    begin
      en(32'h1 | (l << 4));
      far.trig();
      far.trig();
      chk_set(2);
      far.set_line(l - 1, 1'b1);
      far.trig();
      chk_set(0);
      far.trig();
      chk_set(0);
      far.set_line(l - 1, 1'b0);
      en(32'h1 | (l << 1) | ((3 - l) << 4));
      far.trig();
      chk_set(0);
      far.set_line(l - 1, 1'b1);
      far.trig();
      chk_set(1);
      far.trig();
      chk_set(2);
      far.set_line(l - 1, 1'b0);
    end
    $display("test lines done");
    // Inverted restart line: a low line restarts, a high line lets the set advance
    en(32'h0000_0111);
    far.trig();
    chk_set(0);
    far.set_line(0, 1'b1);
    far.trig();
    chk_set(1);
    axr(8'h14, 32'h0000_0301, 2'b00);
    far.set_line(0, 1'b0);
    $display("test invert done");
    en(32'h7);
    far.trig();
    chk_set(0);
    axw(8'h08, 32'h1, 2'b00);
    repeat (2) @(posedge aclk);
    chk_set(1);
    $display("test software done");
    en(32'h1);
    far.rude(0, 1'b1);
    chk_set(0);
    far.set_line(0, 1'b0);
    axw(8'h00, 32'h0, 2'b00);
    $display("test busy done");
    final_report();
  end
endmodule
